/* include/logic_eq_pkg.sv */
// Contract
// - Each equation takes up to four inputs, each picked from the signal set.
// - Each of the four inputs may be inverted individually before the gate.
// - Gate result passes a timer with separate rise and fall delays.
// - Each equation gives a direct delayed result and a latched result together.
// - The complement of the latched result is offered as a further signal.
// - Latch cleared by a selected reset signal, which may be inverted.
// - When reset and set are both active, reset wins.
// - Equations are evaluated in ascending index order, sweep repeated endlessly; here each sweep is started by one eval_tick_i.
// - Any equation output may be selected as input of any other equation.
// - A lower-numbered source gives its value from the same sweep.
// - A higher-numbered source gives its value from the previous sweep.
package logic_eq_pkg;
   localparam int N_EQ     = 8;
   localparam int EQ_W     = 3;
   localparam int N_STAT   = 16;
   localparam int N_SRC    = N_STAT + 3 * N_EQ;
   localparam int SEL_W    = 6;
   localparam int DLY_W    = 16;
   localparam int ADDR_W   = 6;
   localparam int DATA_W   = 32;

   // Source numbering: status inputs, then direct results, latched, inverted latched.
   localparam logic [SEL_W-1:0] SRC_RESULT_BASE = 6'h10;
   localparam logic [SEL_W-1:0] SRC_LATCH_BASE  = 6'h18;
   localparam logic [SEL_W-1:0] SRC_LATCHN_BASE = 6'h20;
   localparam logic [SEL_W-1:0] SEL_NONE        = 6'h3f;

   localparam logic [1:0] GATE_AND  = 2'h0;
   localparam logic [1:0] GATE_OR   = 2'h1;
   localparam logic [1:0] GATE_NAND = 2'h2;
   localparam logic [1:0] GATE_NOR  = 2'h3;

   // Input word: sel0..sel3 in 6-bit fields, inverts at 24..27, gate at 28..29.
   localparam int IN_SEL_POS  = 0;
   localparam int IN_INV_POS  = 24;
   localparam int IN_GATE_POS = 28;
   // Reset word: select at 0, invert at 8.
   localparam int RST_SEL_POS = 0;
   localparam int RST_INV_POS = 8;
   // Timer word: rise delay low half, fall delay high half.
   localparam int RISE_POS    = 0;
   localparam int FALL_POS    = 16;

   localparam logic [DATA_W-1:0] IN_RESET  = 32'h00ffffff;
   localparam logic [DATA_W-1:0] RST_RESET = 32'h0000003f;
   localparam logic [DATA_W-1:0] TMR_RESET = 32'h00000000;

   // Register indices: per equation e, word at e*4 + field.
   localparam logic [1:0]        FLD_INPUT  = 2'h0;
   localparam logic [1:0]        FLD_RESET  = 2'h1;
   localparam logic [1:0]        FLD_TIMER  = 2'h2;
   localparam logic [ADDR_W-1:0] ADDR_STATE = 6'h20;
   localparam logic [ADDR_W-1:0] ADDR_COUNT = 6'h21;

   typedef enum logic {ST_IDLE, ST_SWEEP} sweep_state_type;
endpackage

/* core/equation_gate.sv */
`timescale 1ns/100ps
module equation_gate
   import logic_eq_pkg::*;
(
   input  wire logic [N_SRC-1:0]  src_i,     // Current signal set
   input  wire logic [DATA_W-1:0] in_cfg_i,  // Input selection word
   input  wire logic [DATA_W-1:0] rst_cfg_i, // Reset selection word
   output logic                   gate_o,    // Gate result
   output logic                   reset_o    // Conditioned latch reset
);
   logic [3:0] cond;
   logic [3:0] used;
   logic       and_v;
   logic       or_v;
   logic [1:0] op;
   logic [SEL_W-1:0] rsel;

   genvar k;
   generate
      for (k = 0; k < 4; k++)
      begin : g_in
         wire logic [SEL_W-1:0] sel = in_cfg_i[IN_SEL_POS + k*SEL_W +: SEL_W];
         assign used[k] = (sel < SEL_W'(N_SRC));
         assign cond[k] = used[k] & (src_i[sel] ^ in_cfg_i[IN_INV_POS + k]);
      end
   endgenerate

   // Unused inputs are forced to 1 for AND and 0 for OR, the neutral values.
   assign and_v  = &(cond | ~used);
   assign or_v   = |cond;
   assign op     = in_cfg_i[IN_GATE_POS +: 2];
   assign gate_o = (op == GATE_AND)  ? and_v :
                   (op == GATE_OR)   ? or_v  :
                   (op == GATE_NAND) ? ~and_v : ~or_v;

   // An unassigned reset never clears, even with the invert option set.
   assign rsel    = rst_cfg_i[RST_SEL_POS +: SEL_W];
   assign reset_o = (rsel < SEL_W'(N_SRC)) & (src_i[rsel] ^ rst_cfg_i[RST_INV_POS]);
endmodule // equation_gate

/* core/logic_equation_engine.sv */
// Added by the designer: the address map and the plain strobed port.
`timescale 1ns/100ps
module logic_equation_engine
   import logic_eq_pkg::*;
(
   input  wire logic              sys_clk_i,         // 100 MHz clock
   input  wire logic              rst_i,             // Asynchronous reset, active high
   input  wire logic              eval_tick_i,       // Starts one evaluation sweep
   input  wire logic [N_STAT-1:0] status_i,          // Device status signals
   input  wire logic [ADDR_W-1:0] addr_i,            // Register index
   input  wire logic [DATA_W-1:0] wdata_i,           // Write data
   input  wire logic              wr_i,              // Write strobe
   input  wire logic              rd_i,              // Read strobe
   output logic [DATA_W-1:0]      rdata_o,           // Read data, cycle after rd_i
   output logic [N_EQ-1:0]        equation_result_o, // Direct delayed results
   output logic [N_EQ-1:0]        latched_o,         // Latched results
   output logic [N_EQ-1:0]        latched_n_o,       // Inverted latched results
   output logic                   busy_o             // Sweep in progress
);
   logic [DATA_W-1:0] in_cfg_r  [N_EQ];
   logic [DATA_W-1:0] rst_cfg_r [N_EQ];
   logic [DATA_W-1:0] tmr_cfg_r [N_EQ];
   logic [DLY_W-1:0]  cnt_r     [N_EQ];
   logic [N_EQ-1:0]   result_r;
   logic [N_EQ-1:0]   latch_r;
   logic [N_EQ-1:0]   latch_n_r;
   logic [N_STAT-1:0] stat_snap_r;
   logic [EQ_W-1:0]   idx_r;
   logic [EQ_W-1:0]   idx_nxt;
   logic [DATA_W-1:0] rdata_r;
   logic [DATA_W-1:0] rdata_nxt;
   logic [15:0]       sweep_cnt_r;
   logic              busy_r;
   sweep_state_type   state_r;
   sweep_state_type   state_nxt;

   // Results hold what the sweep has produced so far: entries below idx_r are
   // already from this sweep, entries at or above are from the previous one.
   wire logic [N_SRC-1:0] src = {latch_n_r, latch_r, result_r, stat_snap_r};

   wire logic gate_val;
   wire logic rst_val;

   equation_gate u_gate (
      .src_i     (src),
      .in_cfg_i  (in_cfg_r[idx_r]),
      .rst_cfg_i (rst_cfg_r[idx_r]),
      .gate_o    (gate_val),
      .reset_o   (rst_val)
   );

   wire logic [DLY_W-1:0] rise_dly = tmr_cfg_r[idx_r][RISE_POS +: DLY_W];
   wire logic [DLY_W-1:0] fall_dly = tmr_cfg_r[idx_r][FALL_POS +: DLY_W];
   wire logic             cur_out  = result_r[idx_r];
   wire logic [DLY_W-1:0] cur_cnt  = cnt_r[idx_r];
   wire logic [DLY_W-1:0] need_dly = gate_val ? rise_dly : fall_dly;
   wire logic             differs  = gate_val != cur_out;
   wire logic [DLY_W-1:0] cnt_inc  = cur_cnt + DLY_W'(1);
   // The count holds the number of sweeps the new level has already been seen.
   // Comparing the stored count rather than count+1 keeps the longest delay from wrapping.
   wire logic             expired  = differs & (cur_cnt >= need_dly);
   wire logic             new_out  = expired ? gate_val : cur_out;
   wire logic [DLY_W-1:0] new_cnt  = (!differs || expired) ? '0 : cnt_inc;
   // Reset dominates; the latch is set from the delayed result, not the raw gate.
   wire logic             new_lat  = rst_val ? 1'b0 :
                                     (new_out | latch_r[idx_r]);

   wire logic             in_sweep = (state_r == ST_SWEEP);
   wire logic             last_eq  = (idx_r == EQ_W'(N_EQ - 1));

   always_comb
   begin
      state_nxt = state_r;
      idx_nxt   = idx_r;
      case (state_r)
         ST_IDLE:
         begin
            if (eval_tick_i)
            begin
               state_nxt = ST_SWEEP;
               idx_nxt   = '0;
            end
         end
         ST_SWEEP:
         begin
            idx_nxt = idx_r + EQ_W'(1);
            if (last_eq)
            begin
               state_nxt = ST_IDLE;
               idx_nxt   = '0;
            end
         end
         default:
         begin
            state_nxt = ST_IDLE;
            idx_nxt   = '0;
         end
      endcase
   end

   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         state_r <= ST_IDLE;
         idx_r   <= '0;
         busy_r  <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         idx_r   <= idx_nxt;
         busy_r  <= (state_nxt == ST_SWEEP);
      end
   end

   // Status is frozen for a whole sweep so every equation sees the same inputs.
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
         stat_snap_r <= '0;
      else if (state_r == ST_IDLE && eval_tick_i)
         stat_snap_r <= status_i;
   end

   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         result_r  <= '0;
         latch_r   <= '0;
         latch_n_r <= '1;
         for (int e = 0; e < N_EQ; e++)
            cnt_r[e] <= '0;
      end
      else if (in_sweep)
      begin
         result_r[idx_r]  <= new_out;
         latch_r[idx_r]   <= new_lat;
         latch_n_r[idx_r] <= ~new_lat;
         cnt_r[idx_r]     <= new_cnt;
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
         sweep_cnt_r <= '0;
      else if (in_sweep && last_eq)
         sweep_cnt_r <= sweep_cnt_r + 16'h0001;
   end

   // Register decode. Configuration may change mid-sweep; it takes effect for
   // equations evaluated after the write.
   wire logic            eq_space = ~addr_i[ADDR_W-1];
   wire logic [EQ_W-1:0] wr_eq    = addr_i[EQ_W+1:2];
   wire logic [1:0]      wr_fld   = addr_i[1:0];

   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         for (int e = 0; e < N_EQ; e++)
         begin
            in_cfg_r[e]  <= IN_RESET;
            rst_cfg_r[e] <= RST_RESET;
            tmr_cfg_r[e] <= TMR_RESET;
         end
      end
      else if (wr_i && eq_space)
      begin
         case (wr_fld)
            FLD_INPUT: in_cfg_r[wr_eq]  <= wdata_i & IN_RESET | (wdata_i & 32'h3f000000);
            FLD_RESET: rst_cfg_r[wr_eq] <= wdata_i & 32'h0000013f;
            FLD_TIMER: tmr_cfg_r[wr_eq] <= wdata_i;
            default:   ;
         endcase
      end
   end

   always_comb
   begin
      rdata_nxt = '0;
      if (rd_i)
      begin
         if (eq_space)
         begin
            case (wr_fld)
               FLD_INPUT: rdata_nxt = in_cfg_r[wr_eq];
               FLD_RESET: rdata_nxt = rst_cfg_r[wr_eq];
               FLD_TIMER: rdata_nxt = tmr_cfg_r[wr_eq];
               default:   rdata_nxt = '0;
            endcase
         end
         else if (addr_i == ADDR_STATE)
            rdata_nxt = {busy_r, 7'h00, 8'h00, latch_r, result_r};
         else if (addr_i == ADDR_COUNT)
            rdata_nxt = {16'h0000, sweep_cnt_r};
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
         rdata_r <= '0;
      else
         rdata_r <= rdata_nxt;
   end

   assign rdata_o           = rdata_r;
   assign equation_result_o = result_r;
   assign latched_o         = latch_r;
   assign latched_n_o       = latch_n_r;
   assign busy_o            = busy_r;
endmodule // logic_equation_engine

/* tb/logic_eq_checker_sva.sv */
`timescale 1ns/100ps
module logic_eq_checker
   import logic_eq_pkg::*;
(
   input  wire logic              sys_clk_i,         // Clock
   input  wire logic              rst_i,             // Reset
   input  wire logic              eval_tick_i,       // Sweep tick
   input  wire logic [N_STAT-1:0] status_i,          // Status lines
   input  wire logic [ADDR_W-1:0] addr_i,            // Register index
   input  wire logic [DATA_W-1:0] wdata_i,           // Write data
   input  wire logic              wr_i,              // Write strobe
   input  wire logic              rd_i,              // Read strobe
   input  wire logic [DATA_W-1:0] rdata_o,           // Read data
   input  wire logic [N_EQ-1:0]   equation_result_o, // Direct results
   input  wire logic [N_EQ-1:0]   latched_o,         // Latched results
   input  wire logic [N_EQ-1:0]   latched_n_o,       // Inverted latched
   input  wire logic              busy_o             // Sweep running
);
   logic [3:0]      cnt_r;
   logic [N_EQ-1:0] slot_mask;
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   // Counts busy cycles so each edge of a sweep maps to the one equation it may touch.
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i) cnt_r <= 4'h0;
      else cnt_r <= busy_o ? cnt_r + 4'h1 : 4'h0;
   end
   assign slot_mask = (cnt_r == 4'h0) ? 8'h00 : (8'h01 << (cnt_r - 4'h1));
   sequence s_start; eval_tick_i && !busy_o; endsequence
   sequence s_sweep; busy_o [*8] ##1 !busy_o; endsequence
   property p_sweep_len; s_start |=> s_sweep; endproperty
   a_sweep_len: assert property (p_sweep_len) else $error("sweep length wrong");
   property p_start_cause; $rose(busy_o) |-> $past(eval_tick_i); endproperty
   a_start_cause: assert property (p_start_cause) else $error("sweep without tick");
   property p_quiet; !busy_o && !$past(busy_o) |-> $stable(equation_result_o) && $stable(latched_o); endproperty
   a_quiet: assert property (p_quiet) else $error("outputs moved while idle");
   property p_inv; latched_n_o == ~latched_o; endproperty
   a_inv: assert property (p_inv) else $error("inverted latch mismatch");
   property p_set_src; (latched_o & ~$past(latched_o) & ~equation_result_o) == 8'h00; endproperty
   a_set_src: assert property (p_set_src) else $error("latch set without result");
   property p_state_rd;
      $past(rd_i) && $past(addr_i) == ADDR_STATE && !busy_o && !$past(busy_o)
         |-> rdata_o == {16'h0000, latched_o, equation_result_o};
   endproperty
   a_state_rd: assert property (p_state_rd) else $error("state read mismatch");
   property p_order; ((equation_result_o ^ $past(equation_result_o)) & ~slot_mask) == 8'h00; endproperty
   a_order: assert property (p_order) else $error("result changed out of slot");
   property p_latch_order; ((latched_o ^ $past(latched_o)) & ~slot_mask) == 8'h00; endproperty
   a_latch_order: assert property (p_latch_order) else $error("latch changed out of slot");
endmodule // logic_eq_checker

bind logic_equation_engine logic_eq_checker i_logic_eq_checker (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
   .eval_tick_i(eval_tick_i), .status_i(status_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
   .rd_i(rd_i), .rdata_o(rdata_o), .equation_result_o(equation_result_o), .latched_o(latched_o),
   .latched_n_o(latched_n_o), .busy_o(busy_o));

/* tb/relay_side_model.sv */
`timescale 1ns/100ps
module relay_side_model
   import logic_eq_pkg::*;
(
   input  wire logic              sys_clk_i, // Clock
   input  wire logic              rst_i,     // Reset
   input  wire logic              go_i,      // Request one sweep
   input  wire logic [N_STAT-1:0] stat_i,    // Status to present
   input  wire logic              busy_i,    // Engine busy
   output logic                   tick_o,    // Sweep tick
   output logic [N_STAT-1:0]      status_o   // Status lines
);
   // The tick is only raised while idle, since a tick during a sweep is lost.
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         tick_o   <= 1'b0;
         status_o <= '0;
      end
      else
      begin
         tick_o <= go_i && !busy_i && !tick_o;
         if (go_i)
         begin
            status_o <= stat_i;
         end
      end
   end
endmodule // relay_side_model

/* tb/tb.sv */
`timescale 1ns/100ps
module tb;
   import logic_eq_pkg::*;
   logic sys_clk_i, rst_i, go, wr_i, rd_i, tick, busy_o;
   logic [N_STAT-1:0] stat, status;
   logic [ADDR_W-1:0] addr_i;
   logic [DATA_W-1:0] wdata_i, rdata_o;
   logic [N_EQ-1:0]   res, lat, lat_n;
   int n_fail, total_checks;
   // Row: gate, inverts, status bits 3..0, expected result of equation 0.
   logic [10:0] rows [9] = '{{2'h0,4'h0,4'hf,1'h1}, {2'h0,4'h0,4'h7,1'h0}, {2'h0,4'h8,4'h7,1'h1},
      {2'h1,4'h0,4'h0,1'h0}, {2'h1,4'h2,4'h0,1'h1}, {2'h2,4'h0,4'hf,1'h0}, {2'h2,4'h0,4'he,1'h1},
      {2'h3,4'h0,4'h0,1'h1}, {2'h3,4'h0,4'h4,1'h0}};
   logic_equation_engine i_logic_equation_engine (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .eval_tick_i(tick),
      .status_i(status), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .equation_result_o(res), .latched_o(lat), .latched_n_o(lat_n), .busy_o(busy_o));
   relay_side_model i_relay_side_model (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .go_i(go), .stat_i(stat),
      .busy_i(busy_o), .tick_o(tick), .status_o(status));
   task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      total_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
      end
   endtask
   task wr(input logic [5:0] a, input logic [31:0] d);
      @(posedge sys_clk_i);
      wr_i    <= 1'b1;
      addr_i  <= a;
      wdata_i <= d;
      @(posedge sys_clk_i);
      wr_i <= 1'b0;
   endtask
   task rd(input logic [5:0] a, input logic [31:0] exp);
      @(posedge sys_clk_i);
      rd_i   <= 1'b1;
      addr_i <= a;
      @(posedge sys_clk_i);
      rd_i <= 1'b0;
      #1 chk(rdata_o, exp, "read");
   endtask
   // A sweep lasts eight busy cycles; twelve edges leave margin for the tick path.
   task sweep(input logic [15:0] s);
      @(posedge sys_clk_i);
      go   <= 1'b1;
      stat <= s;
      @(posedge sys_clk_i);
      go <= 1'b0;
      repeat (12) @(posedge sys_clk_i);
      #1 chk(busy_o, 1'b0, "busy");
   endtask
   task finish_test;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial
   begin
      sys_clk_i = 1'b0;
      forever #5 sys_clk_i = ~sys_clk_i;
   end
   initial
   begin
      #100000 n_fail++;
      finish_test;
   end
   initial
   begin
      rst_i        = 1'b1;
      go           = 1'b0;
      stat         = '0;
      addr_i       = '0;
      wdata_i      = '0;
      wr_i         = 1'b0;
      rd_i         = 1'b0;
      n_fail       = 0;
      total_checks = 0;
      repeat (4) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      chk({res, lat, lat_n}, 24'h0000ff, "reset outputs");
      rd(6'h00, IN_RESET);
      rd(6'h01, RST_RESET);
      rd(6'h02, TMR_RESET);
      wr(6'h0c, 32'h10ffffc5);
      wr(6'h0d, 32'h00000006);
      wr(6'h0e, 32'h00010002);
      wr(6'h10, 32'h10ffffd6);
      wr(6'h14, 32'h10ffffd4);
      wr(6'h18, 32'h10ffffc7);
      $display("reset test done");
      foreach (rows[i])
      begin
         wr(6'h00, {2'h0, rows[i][10:9], rows[i][8:5], 24'h0c2040});
         sweep({12'h000, rows[i][4:1]});
         chk(res[0], rows[i][0], "gate row");
      end
      $display("gate table done");
      sweep(16'h0080);
      chk(res[6:4], 3'b100, "descending cascade");
      sweep(16'h0080);
      chk(res[6:4], 3'b111, "ascending cascade");
      $display("cascade test done");
      sweep(16'h0020);
      sweep(16'h0020);
      chk({res[3], lat[3]}, 2'b00, "rise delay");
      sweep(16'h0020);
      chk({res[3], lat[3], lat_n[3]}, 3'b110, "rise done");
      sweep(16'h0060);
      chk({res[3], lat[3]}, 2'b10, "reset wins");
      sweep(16'h0020);
      chk(lat[3], 1'b1, "latch set again");
      wr(6'h0d, 32'h00000106);
      sweep(16'h0000);
      chk({res[3], lat[3]}, 2'b10, "inverted reset, fall pending");
      wr(6'h0d, 32'h0000003f);
      sweep(16'h0000);
      chk({res[3], lat[3]}, 2'b00, "fall done");
      // Unconfigured equations 1, 2 and 7 sit at 1 because an empty AND is true.
      rd(ADDR_STATE, 32'h0000f787);
      rd(ADDR_COUNT, 32'h00000012);
      $display("timer and latch test done");
      @(posedge sys_clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      chk({res, lat, lat_n}, 24'h0000ff, "mid-run reset outputs");
      rd(6'h0c, IN_RESET);
      rd(ADDR_COUNT, 32'h00000000);
      sweep(16'h0000);
      chk({res, lat}, 16'hffff, "unassigned inputs neutral");
      $display("mid-run reset test done");
      finish_test;
   end
endmodule // tb
